// [src/mmbc_pkg.sv]
// shared constants and types for the minimum-mode bus control block
package mmbc_pkg;
   // bus cycle kinds requested by the execution side
   typedef enum logic [1:0] {
      MMBC_CYC_READ,
      MMBC_CYC_WRITE,
      MMBC_CYC_IRQ_ACK_STROBE_N
   } mmbc_cyc_e;

   // one clock of the block is one half of a processor T state
   localparam int unsigned MMBC_PHASES_PER_T = 2;
   localparam logic        MMBC_PHASE_HIGH   = 1'b0;
   localparam logic        MMBC_PHASE_LOW    = 1'b1;

   // idle levels of the strobes
   localparam logic MMBC_STROBE_IDLE = 1'b1;
   localparam logic MMBC_FLOAT_LEVEL = 1'b1;
   localparam logic MMBC_ALE_IDLE    = 1'b0;
endpackage : mmbc_pkg

// [src/mmbc_if.sv]
// synchroniser carrier between top and its input stage
`timescale 1ns/1ps
`default_nettype none
interface mmbc_if;
   logic hold_raw;
   logic hold_sync;
   modport top  (output hold_raw, input hold_sync);
   modport sync (input hold_raw, output hold_sync);
endinterface : mmbc_if
`default_nettype wire

// [src/mmbc_sync.sv]
// two flip-flop synchroniser for the hold request input
`timescale 1ns/1ps
`default_nettype none
module mmbc_sync
   import mmbc_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic clk_en,
   mmbc_if.sync      link
);
   typedef struct packed {
      logic meta;
      logic sync;
   } mmbc_sync_s;

   mmbc_sync_s st_ff;
   mmbc_sync_s nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (clk_en) begin
         nxt_st.meta = link.hold_raw;
         nxt_st.sync = st_ff.meta;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign link.hold_sync = st_ff.sync;
endmodule : mmbc_sync
`default_nettype wire

// [src/mmbc_top.sv]
// minimum-mode bus control: T-state sequencer, strobes and hold exchange
// Operation
// - space indicator high for memory cycles, low for I/O cycles
// - space indicator valid from preceding T4 until final T4 of cycle
// - during hold acknowledge space, direction and enable float as logic one
// - write strobe low during T2, T3 and waits of write cycles
// - during hold acknowledge write strobe floats as logic one
// - interrupt acknowledge strobe low during T2, T3 and waits of acknowledge cycles
// - interrupt acknowledge strobe always driven, never floated
// - address latch enable pulses high in clock-low half of T1
// - address latch enable always driven, never floated
// - direction high transmit, low receive, timed like space indicator
// - transceiver enable low for memory, I/O and acknowledge cycles
// - read and acknowledge cycles enable from mid T2 to mid T4
// - write cycles enable from start of T2 to mid T4
// - hold acknowledge rises in middle of a T4 or idle state
// - bus and controls float in same cycle as hold acknowledge
// - hold request low drops acknowledge at a T state boundary; lines driven again in that same cycle
`timescale 1ns/1ps
`default_nettype none
module mmbc_top
   import mmbc_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       clk_en,
   input  wire logic       cyc_req,
   input  wire logic [1:0] cyc_kind,
   input  wire logic       cyc_mem,
   input  wire logic       ready,
   input  wire logic       hold_req,
   output logic            cyc_done,
   output logic            space_out,
   output logic            space_oe,
   output logic            xcvr_direction,
   output logic            xcvr_direction_oe,
   output logic            xcvr_enable_n,
   output logic            xcvr_enable_oe,
   output logic            write_strobe_n,
   output logic            write_strobe_oe,
   output logic            irq_ack_strobe_n,
   output logic            ale,
   output logic            bus_grant_out
);
   typedef enum logic [2:0] {
      MMBC_TI,
      MMBC_T1,
      MMBC_T2,
      MMBC_T3,
      MMBC_TW,
      MMBC_T4
   } mmbc_state_e;

   typedef struct packed {
      mmbc_state_e state;
      logic        phase;
      logic [1:0]  kind;
      logic        mem;
      logic        grant;
      logic        drive;
      logic        done;
      logic        space;
      logic        dir;
      logic        den_n;
      logic        wr_n;
      logic        irq_ack_strobe_n_n;
      logic        ale;
   } mmbc_top_s;

   mmbc_top_s st_ff;
   mmbc_top_s nxt_st;
   logic      hold_s;
   logic      end_of_t;

   mmbc_if link ();

   assign link.hold_raw = hold_req;
   assign hold_s        = link.hold_sync;

   mmbc_sync u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .link    (link)
   );

   assign end_of_t = (st_ff.phase == MMBC_PHASE_LOW);

   always_comb begin
      nxt_st = st_ff;
      if (clk_en) begin
         // done is state too, so it freezes with the rest while disabled
         nxt_st.done  = 1'b0;
         nxt_st.phase = ~st_ff.phase;
         if (end_of_t) begin
            case (st_ff.state)
               MMBC_TI, MMBC_T4: begin
                  // at a T state boundary with no bus work, hold keeps the sequencer idle and its drop releases the grant
                  if (st_ff.grant) begin
                     if (!hold_s) begin
                        nxt_st.grant = 1'b0;
                     end
                     nxt_st.state = MMBC_TI;
                  end else if (hold_s) begin
                     nxt_st.state = MMBC_TI;
                  end else if (cyc_req) begin
                     nxt_st.state = MMBC_T1;
                     nxt_st.kind  = cyc_kind;
                     nxt_st.mem   = cyc_mem;
                     // a request seen only in the low half still gets valid lines in T1
                     nxt_st.space = cyc_mem;
                     nxt_st.dir   = (cyc_kind == MMBC_CYC_WRITE);
                  end else begin
                     nxt_st.state = MMBC_TI;
                  end
               end
               MMBC_T1: nxt_st.state = MMBC_T2;
               MMBC_T2: nxt_st.state = MMBC_T3;
               MMBC_T3, MMBC_TW: begin
                  // ready sampled directly; the source meets setup and hold
                  nxt_st.state = ready ? MMBC_T4 : MMBC_TW;
                  nxt_st.done  = ready;
               end
               default: nxt_st.state = MMBC_TI;
            endcase
         end else begin
            // middle of T4 or idle: raise acknowledge and float at once
            if ((st_ff.state == MMBC_TI || st_ff.state == MMBC_T4) && hold_s
                && !st_ff.grant && !(st_ff.state == MMBC_T4 && cyc_req)) begin
               nxt_st.grant = 1'b1;
            end
         end

         // space and direction set in the T4 before the cycle, held to its final T4
         if (!end_of_t && cyc_req && !hold_s && !st_ff.grant
             && (st_ff.state == MMBC_TI || st_ff.state == MMBC_T4)) begin
            nxt_st.space = cyc_mem;
            nxt_st.dir   = (cyc_kind == MMBC_CYC_WRITE);
         end

         // ale high during the clock-low half of T1
         nxt_st.ale = (nxt_st.state == MMBC_T1) && (nxt_st.phase == MMBC_PHASE_LOW);

         nxt_st.wr_n   = MMBC_STROBE_IDLE;
         nxt_st.irq_ack_strobe_n_n = MMBC_STROBE_IDLE;
         nxt_st.den_n  = MMBC_STROBE_IDLE;
         case (nxt_st.state)
            MMBC_T2: begin
               if (nxt_st.kind == MMBC_CYC_WRITE) begin
                  nxt_st.wr_n  = 1'b0;
                  nxt_st.den_n = 1'b0;
               end else begin
                  nxt_st.den_n = (nxt_st.phase == MMBC_PHASE_HIGH);
               end
               nxt_st.irq_ack_strobe_n_n = (nxt_st.kind != MMBC_CYC_IRQ_ACK_STROBE_N);
            end
            MMBC_T3, MMBC_TW: begin
               nxt_st.wr_n   = (nxt_st.kind != MMBC_CYC_WRITE);
               nxt_st.irq_ack_strobe_n_n = (nxt_st.kind != MMBC_CYC_IRQ_ACK_STROBE_N);
               nxt_st.den_n  = 1'b0;
            end
            MMBC_T4: begin
               // enable ends in the middle of T4
               nxt_st.den_n = (nxt_st.phase == MMBC_PHASE_LOW);
            end
            default: begin
            end
         endcase

         // floated lines carry one in the flops so the pins stay straight flop outputs
         if (nxt_st.grant) begin
            nxt_st.space = MMBC_FLOAT_LEVEL;
            nxt_st.dir   = MMBC_FLOAT_LEVEL;
            nxt_st.den_n = MMBC_FLOAT_LEVEL;
            nxt_st.wr_n  = MMBC_FLOAT_LEVEL;
         end
         nxt_st.drive = ~nxt_st.grant;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_ff        <= '0;
         st_ff.state  <= MMBC_TI;
         st_ff.phase  <= MMBC_PHASE_HIGH;
         st_ff.drive  <= 1'b1;
         st_ff.space  <= MMBC_FLOAT_LEVEL;
         st_ff.dir    <= MMBC_FLOAT_LEVEL;
         st_ff.den_n  <= MMBC_STROBE_IDLE;
         st_ff.wr_n   <= MMBC_STROBE_IDLE;
         st_ff.irq_ack_strobe_n_n <= MMBC_STROBE_IDLE;
         st_ff.ale    <= MMBC_ALE_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // floated pins carry one as their value so the pull-up level is mirrored
   assign space_out         = st_ff.space;
   assign space_oe          = st_ff.drive;
   assign xcvr_direction    = st_ff.dir;
   assign xcvr_direction_oe = st_ff.drive;
   assign xcvr_enable_n     = st_ff.den_n;
   assign xcvr_enable_oe    = st_ff.drive;
   assign write_strobe_n    = st_ff.wr_n;
   assign write_strobe_oe   = st_ff.drive;
   assign irq_ack_strobe_n  = st_ff.irq_ack_strobe_n_n;
   assign ale               = st_ff.ale;
   assign bus_grant_out     = st_ff.grant;
   assign cyc_done          = st_ff.done;
endmodule : mmbc_top
`default_nettype wire

// [test/mmbc_checker.sv]
// concurrent checks on the bus control outputs
`timescale 1ns/1ps
`default_nettype none
module mmbc_checker (
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire logic [1:0] cyc_kind,
   input wire logic       cyc_mem,
   input wire logic       ready,
   input wire logic       hold_req,
   input wire logic       cyc_done,
   input wire logic       space_out,
   input wire logic       space_oe,
   input wire logic       xcvr_direction,
   input wire logic       xcvr_enable_n,
   input wire logic       xcvr_enable_oe,
   input wire logic       write_strobe_n,
   input wire logic       write_strobe_oe,
   input wire logic       irq_ack_strobe_n,
   input wire logic       ale,
   input wire logic       bus_grant_out
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_ale; ale |=> !ale; endproperty
   a_ale: assert property (p_ale) else $error("ale width");
   property p_spc; ale |-> space_out == cyc_mem && xcvr_direction == (cyc_kind == 2'h1);
   endproperty
   a_spc: assert property (p_spc) else $error("space or dir");
   property p_stb; ale |=> $stable({space_out, xcvr_direction})[*4]; endproperty
   a_stb: assert property (p_stb) else $error("space moved");
   property p_wr; ale |=> write_strobe_n == (cyc_kind != 2'h1); endproperty
   a_wr: assert property (p_wr) else $error("write strobe");
   property p_ia; ale |=> irq_ack_strobe_n == (cyc_kind != 2'h2); endproperty
   a_ia: assert property (p_ia) else $error("ack strobe");
   property p_den; ale |=> xcvr_enable_n == (cyc_kind != 2'h1) ##1 !xcvr_enable_n; endproperty
   a_den: assert property (p_den) else $error("xcvr enable");
   property p_flt;
      bus_grant_out |-> !(space_oe | xcvr_enable_oe | write_strobe_oe) && space_out
         && write_strobe_n && xcvr_enable_n && !ale;
   endproperty
   a_flt: assert property (p_flt) else $error("not floated");
   property p_rdy; cyc_done |-> $past(ready); endproperty
   a_rdy: assert property (p_rdy) else $error("done w/o ready");
   property p_gnt; $rose(bus_grant_out) |-> $past(hold_req, 2); endproperty
   a_gnt: assert property (p_gnt) else $error("grant w/o hold");
   property p_rel; !hold_req [*6] |=> !bus_grant_out; endproperty
   a_rel: assert property (p_rel) else $error("grant stuck");
   c_ia: cover property (ale && cyc_kind == 2'h2);
   c_gnt: cover property ($rose(bus_grant_out));
   c_wait: cover property (cyc_done && !$past(ready, 3));
endmodule : mmbc_checker
bind mmbc_top mmbc_checker i_mmbc_checker (.*);
`default_nettype wire

// [test/mmbc_partner.sv]
// far side: addressed device ready and a second bus master
`timescale 1ns/1ps
`default_nettype none
module mmbc_partner (
   input  wire logic       clk_sys,
   input  wire logic       ale,
   input  wire logic [3:0] waits,
   input  wire logic       hold_want,
   output var logic        ready,
   output var logic        hold_req
);
   int cnt = 100;
   initial hold_req = 1'b0;
   always @(posedge clk_sys) begin
      cnt <= ale ? 1 : cnt + 1;
      hold_req <= #1 hold_want;
   end
   // not-ready until the chosen waits, toggles once the window is over
   assign ready = (cnt >= 4 + 2 * waits) && (cnt <= 5 + 2 * waits || cnt[0]);
endmodule : mmbc_partner
`default_nettype wire

// [test/min_mode_bus_control_tb.sv]
// self-checking bench for the bus control block
`timescale 1ns/1ps
`default_nettype none
module min_mode_bus_control_tb;
   logic       clk_sys = 1'b0;
   logic       rst_n = 1'b0;
   logic       cyc_req = 1'b0;
   logic [1:0] cyc_kind = 2'h0;
   logic       cyc_mem = 1'b0;
   logic [3:0] waits = 4'h0;
   logic       hold_want = 1'b0;
   logic       clk_en = 1'b1;
   logic [6:0] snap;
   logic       ready, hold_req, cyc_done, space_out, space_oe, xcvr_direction;
   logic       xcvr_direction_oe, xcvr_enable_n, xcvr_enable_oe, write_strobe_n;
   logic       write_strobe_oe, irq_ack_strobe_n, ale, bus_grant_out;
   int         n_fail = 0, n_checks = 0, cyc_cnt = 0, na, t;
   int         exp_q[$];
   mmbc_top i_mmbc_top (.*);
   mmbc_partner i_mmbc_partner (.*);
   initial forever #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         n_fail++;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks=%0d fails=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   // last high drops the request, else the next cycle follows back to back
   task automatic run_cyc(input logic [1:0] k, input logic m, input logic [3:0] w,
                          input logic last);
      int n = 0, nw = 0, ni = 0, nd = 0, nl = 0, e;
      @(posedge clk_sys);
      #1;
      {cyc_kind, cyc_mem, waits, cyc_req} = {k, m, w, 1'b1};
      exp_q.push_back(4 + 2 * w);
      do begin
         @(negedge clk_sys);
         n++;
         nw += !write_strobe_n;
         ni += !irq_ack_strobe_n;
         nd += !xcvr_enable_n;
         nl += ale;
      end while (cyc_done !== 1'b1 && n < 100);
      e = exp_q.pop_front();
      chk(nw, k == 2'h1 ? e : 0);
      chk(ni, k == 2'h2 ? e : 0);
      chk(nd, k == 2'h1 ? e + 1 : e);
      chk(nl, 1);
      chk({space_out, xcvr_direction}, {m, k == 2'h1});
      if (last) begin
         @(posedge clk_sys);
         #1;
         cyc_req = 1'b0;
      end
   endtask : run_cyc
   initial begin
      void'($urandom(98));
      repeat (4) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      chk({space_out, xcvr_direction, xcvr_enable_n, write_strobe_n, irq_ack_strobe_n, ale,
           bus_grant_out}, 7'h7C);
      for (int i = 0; i < 24; i++) begin
         run_cyc(2'(i % 3), 1'($urandom), 4'($urandom_range(3)), 1'b0);
         run_cyc(2'(i % 3), cyc_mem, 4'($urandom_range(3)), 1'b1);
      end
      // frozen block must keep its space, direction, enable, strobe, ale and grant lines while a request waits
      @(posedge clk_sys);
      #1;
      clk_en = 1'b0;
      cyc_req = 1'b1;
      snap = {space_out, xcvr_direction, xcvr_enable_n, write_strobe_n, irq_ack_strobe_n, ale,
              bus_grant_out};
      repeat (6) @(negedge clk_sys);
      chk({space_out, xcvr_direction, xcvr_enable_n, write_strobe_n, irq_ack_strobe_n, ale,
           bus_grant_out}, snap);
      @(posedge clk_sys);
      #1;
      clk_en = 1'b1;
      cyc_req = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      hold_want = 1'b1;
      for (t = 0; t < 20 && bus_grant_out !== 1'b1; t++) @(negedge clk_sys);
      chk({bus_grant_out, space_oe, xcvr_direction_oe, xcvr_enable_oe, write_strobe_oe,
           space_out, xcvr_direction, xcvr_enable_n, write_strobe_n, irq_ack_strobe_n,
           ale}, 11'h43E);
      @(posedge clk_sys);
      #1;
      cyc_req = 1'b1;
      na = 0;
      repeat (12) @(negedge clk_sys) na += ale;
      chk(na, 0);
      @(posedge clk_sys);
      #1;
      hold_want = 1'b0;
      run_cyc(2'h1, 1'b1, 4'h2, 1'b1);
      chk(bus_grant_out, 1'b0);
      end_sim();
   end
endmodule : min_mode_bus_control_tb
`default_nettype wire
